// ==== cim_pkg.sv ====
// shared constants, types and register map of the counter input measurement block
package cim_pkg;

  // ==========================================================================
  // register map (byte offsets on the wishbone bus)
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL   = 8'h00; // configuration word
  localparam logic [7:0] OFF_CMD    = 8'h04; // arm / disarm command strobes
  localparam logic [7:0] OFF_COUNT  = 8'h08; // live count, read only
  localparam logic [7:0] OFF_SAVE   = 8'h0C; // latched result, read only
  localparam logic [7:0] OFF_STATUS = 8'h10; // state flags, write one to clear overflow

  // ==========================================================================
  // field positions and reset values
  // ==========================================================================
  localparam int CMD_ARM_BIT    = 0;     // write 1 arms the counter
  localparam int CMD_DISARM_BIT = 1;     // write 1 stops the counter
  localparam int STS_ARMED_BIT  = 0;     // counter is running or waiting
  localparam int STS_DONE_BIT   = 1;     // single measurement finished
  localparam int STS_OVF_BIT    = 2;     // sample lost on a full fifo, sticky
  localparam int STS_LEVEL_LSB  = 8;     // fifo fill level starts here
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] STEP_UP     = 32'h0000_0001;
  localparam logic [31:0] STEP_DOWN   = 32'hFFFF_FFFF;

  // ==========================================================================
  // enumerations
  // ==========================================================================
  // measurement modes, as written into the mode field
  typedef enum logic [2:0] {
    MODE_COUNT,       // on-demand edge counting
    MODE_BUF_CUM,     // sampled edge counting, total since arming
    MODE_BUF_NONCUM,  // sampled edge counting, cleared per interval
    MODE_PW_SINGLE,   // one pulse width
    MODE_PW_BUF,      // every pulse width
    MODE_PER_SINGLE,  // one period
    MODE_PER_BUF      // every period
  } mode_e;

  // count direction choices
  typedef enum logic [1:0] {
    DIR_UP,
    DIR_DOWN,
    DIR_AUX           // up while the aux input is high
  } dir_e;

  // measurement sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_IDLE,     // gate was active at arming, wait for it to drop
    ST_WAIT_START,    // wait for the opening gate event
    ST_MEASURE,
    ST_DONE
  } state_e;

  // ==========================================================================
  // configuration word layout
  // ==========================================================================
  typedef struct packed {
    logic [12:0] rsvd;       // reads as zero
    logic [2:0]  dir_sel;    // input line used as direction
    logic [2:0]  gate_sel;   // input line used as gate
    logic [2:0]  src_sel;    // input line used as source
    dir_e        dir_mode;
    logic        pw_high;    // 1: measure high pulses
    logic        gate_rise;  // 1: gate active edge is rising
    logic        pause_high; // 1: pause while gate is high
    logic        pause_en;   // gate pauses edge counting
    logic        src_rise;   // 1: count rising source edges
    mode_e       mode;
  } ctrl_s;

  // one captured result on its way to the dma path
  typedef struct packed {
    logic        valid;
    logic [31:0] value;
  } sample_s;

endpackage : cim_pkg

// ==== counter_input_measurement.sv ====
// sample fifo and the counter input measurement top with its wishbone slave
`timescale 1ns/1ps


// ============================================================================
// sample fifo: memory plus a registered output stage
// ============================================================================
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i,
  // fill level of the memory part
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  // pointer wrap relies on a power-of-two depth
  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0))
  begin : g_bad_depth
    $error("sample_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];          // storage words
  logic [PW-1:0]    wr_ptr, next_wr_ptr;  // next slot to write
  logic [PW-1:0]    rd_ptr, next_rd_ptr;  // next slot to read
  logic [LW-1:0]    used, next_used;      // words held in memory
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             do_wr;
  logic             do_rd;

  // next values: write when not full, refill output stage when it frees up
  always_comb
  begin
    do_wr          = in_valid_i && (used != LW'(DEPTH));
    do_rd          = (used != '0) && (!out_valid_o || out_ready_i);
    next_wr_ptr    = do_wr ? wr_ptr + PW'(1) : wr_ptr;
    next_rd_ptr    = do_rd ? rd_ptr + PW'(1) : rd_ptr;
    next_used      = used + LW'(do_wr) - LW'(do_rd);
    next_out_valid = out_valid_o;
    next_out_data  = out_data_o;
    if (do_rd)
    begin
      next_out_valid = 1'b1;
      next_out_data  = mem[rd_ptr];
    end
    else if (out_ready_i)
    begin
      next_out_valid = 1'b0;  // word taken, nothing behind it
    end
  end

  // registers; memory itself needs no reset
  always_ff @(posedge clk_i)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data_i;
    end
    if (rst_i)
    begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      used        <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      in_ready_o  <= 1'b0;
    end
    else
    begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      used        <= next_used;
      out_valid_o <= next_out_valid;
      out_data_o  <= next_out_data;
      // registered ready matches the write test: a flagged drop is never stored
      in_ready_o  <= (next_used != LW'(DEPTH));
    end
  end

  assign level_o = used;

endmodule : sample_fifo

// ============================================================================
// counter input measurement top
// ============================================================================
module counter_input_measurement #(
  parameter int NUM_INPUTS = 7,  // routed input lines
  parameter int FIFO_DEPTH = 8   // dma buffer words
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // routed counter inputs
  input  wire logic [NUM_INPUTS-1:0] ctr_in_i,
  // dma stream of captured values
  output logic                       dma_valid_o,
  output logic      [31:0]           dma_data_o,
  input  wire logic                  dma_ready_i
);
  import cim_pkg::*;

  if ((NUM_INPUTS < 1) || (NUM_INPUTS > 8))
  begin : g_bad_inputs
    $error("counter_input_measurement needs 1 to 8 input lines");
  end

  // ==========================================================================
  // input synchronisers and edge history
  // ==========================================================================
  logic [NUM_INPUTS-1:0] meta;   // first stage, read only by the second
  logic [NUM_INPUTS-1:0] sync;   // safe level
  logic [NUM_INPUTS-1:0] hist;   // level one cycle earlier, for edges

  for (genvar i = 0; i < NUM_INPUTS; i++)
  begin : g_sync
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        meta[i] <= 1'b0;
        sync[i] <= 1'b0;
        hist[i] <= 1'b0;
      end
      else
      begin
        meta[i] <= ctr_in_i[i];
        sync[i] <= meta[i];
        hist[i] <= sync[i];
      end
    end
  end

  // ==========================================================================
  // register file state
  // ==========================================================================
  ctrl_s       ctrl, next_ctrl;          // configuration
  logic        arm_req, next_arm_req;    // one-cycle arm pulse
  logic        stop_req, next_stop_req;  // one-cycle disarm pulse
  logic        ovf_clr, next_ovf_clr;    // one-cycle overflow clear
  logic [31:0] next_rdata;
  logic        next_ack;
  logic        bus_req;

  // ==========================================================================
  // counter state
  // ==========================================================================
  state_e      state, next_state;
  logic [31:0] count, next_count;        // running count, wraps freely
  logic [31:0] save, next_save;          // latched result
  logic        done, next_done;
  logic        ovf, next_ovf;
  logic        push;                     // capture toward the dma path
  logic [31:0] push_data;
  logic        fifo_ready;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;

  // selected lines; an unused selector reads as a quiet low line
  logic src_lvl, src_old, gate_lvl, gate_old, dir_lvl;
  logic src_ev, gate_rise_ev, gate_fall_ev, sample_ev;
  logic gate_act, gate_was_act, gate_enter, gate_leave;
  logic paused;
  logic [31:0] delta;                    // step for edge counting modes
  logic [31:0] stepped;                  // count after this cycle's edge

  always_comb
  begin
    src_lvl  = (int'(ctrl.src_sel) < NUM_INPUTS) ? sync[ctrl.src_sel] : 1'b0;
    src_old  = (int'(ctrl.src_sel) < NUM_INPUTS) ? hist[ctrl.src_sel] : 1'b0;
    gate_lvl = (int'(ctrl.gate_sel) < NUM_INPUTS) ? sync[ctrl.gate_sel] : 1'b0;
    gate_old = (int'(ctrl.gate_sel) < NUM_INPUTS) ? hist[ctrl.gate_sel] : 1'b0;
    dir_lvl  = (int'(ctrl.dir_sel) < NUM_INPUTS) ? sync[ctrl.dir_sel] : 1'b0;
  end

  // event decoding from synchronised levels
  always_comb
  begin
    src_ev       = ctrl.src_rise ? (src_lvl && !src_old) : (!src_lvl && src_old);
    gate_rise_ev = gate_lvl && !gate_old;
    gate_fall_ev = !gate_lvl && gate_old;
    // same-direction gate edges mark sample points
    sample_ev    = ctrl.gate_rise ? gate_rise_ev : gate_fall_ev;
    gate_act     = (gate_lvl == ctrl.pw_high);
    gate_was_act = (gate_old == ctrl.pw_high);
    gate_enter   = gate_act && !gate_was_act;
    gate_leave   = !gate_act && gate_was_act;
    paused       = ctrl.pause_en && (gate_lvl == ctrl.pause_high);
    case (ctrl.dir_mode)
      DIR_UP:   delta = STEP_UP;
      DIR_DOWN: delta = STEP_DOWN;
      DIR_AUX:  delta = dir_lvl ? STEP_UP : STEP_DOWN;
      default:  delta = STEP_UP;
    endcase
  end

  // ==========================================================================
  // measurement sequencer
  // ==========================================================================
  // next values of count, result, flags and state
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_save  = save;
    next_done  = done;
    push       = 1'b0;
    push_data  = count;
    stepped    = count;
    case (ctrl.mode)
      // add and subtract wrap modulo 32 bits
      MODE_COUNT, MODE_BUF_CUM, MODE_BUF_NONCUM:
        stepped = (src_ev && !paused) ? count + delta : count;
      default:
        stepped = src_ev ? count + STEP_UP : count;
    endcase
    case (state)
      ST_IDLE, ST_DONE:
      begin
        // finished single measurement ignores all edges
        next_state = state;
      end
      ST_WAIT_IDLE:
      begin
        // let the pulse in progress pass
        if (!gate_act)
        begin
          next_state = ST_WAIT_START;
        end
      end
      ST_WAIT_START:
      begin
        // opening event: pulse start for width, active edge for period
        if (((ctrl.mode == MODE_PW_SINGLE) || (ctrl.mode == MODE_PW_BUF)) ? gate_enter : sample_ev)
        begin
          next_state = ST_MEASURE;
          next_count = COUNT_RESET;
        end
      end
      ST_MEASURE:
      begin
        case (ctrl.mode)
          MODE_COUNT:
          begin
            next_count = stepped;
          end
          MODE_BUF_CUM:
          begin
            next_count = stepped;
            if (sample_ev)
            begin
              push      = 1'b1;
              next_save = count;
            end
          end
          MODE_BUF_NONCUM:
          begin
            next_count = stepped;
            if (sample_ev)
            begin
              push      = 1'b1;
              next_save = count;
              // restart the interval, an edge now opens the next one
              next_count = (src_ev && !paused) ? delta : COUNT_RESET;
            end
          end
          MODE_PW_SINGLE, MODE_PW_BUF:
          begin
            // count only inside the active pulse
            if (gate_leave)
            begin
              next_save = count;
              if (ctrl.mode == MODE_PW_BUF)
              begin
                // latch every trailing edge and pass it on
                push       = 1'b1;
                next_state = ST_WAIT_START;
              end
              else
              begin
                next_done  = 1'b1;
                next_state = ST_DONE;
              end
            end
            else
            begin
              next_count = stepped;
            end
          end
          MODE_PER_SINGLE, MODE_PER_BUF:
          begin
            // source edges between two active gate edges
            next_count = stepped;
            if (sample_ev)
            begin
              next_save  = count;
              next_count = src_ev ? STEP_UP : COUNT_RESET;
              if (ctrl.mode == MODE_PER_BUF)
              begin
                push = 1'b1;
              end
              else
              begin
                next_done  = 1'b1;
                next_state = ST_DONE;
              end
            end
          end
          default:
          begin
            next_state = ST_IDLE;  // unused mode code halts the counter
          end
        endcase
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    // arming clears count and measurement state
    if (arm_req)
    begin
      next_count = COUNT_RESET;
      next_done  = 1'b0;
      case (ctrl.mode)
        MODE_PW_SINGLE, MODE_PW_BUF:
          // armed mid-pulse waits for the next pulse
          next_state = gate_act ? ST_WAIT_IDLE : ST_WAIT_START;
        MODE_PER_SINGLE:
          next_state = ST_WAIT_START;
        // edge counts and buffered periods run from arming
        default:
          next_state = ST_MEASURE;
      endcase
    end
    else if (stop_req)
    begin
      next_state = ST_IDLE;
    end
    // lost capture sets the flag; a set in the clear cycle wins
    next_ovf = (ovf && !ovf_clr) || (push && !fifo_ready);
  end

  // sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      count <= COUNT_RESET;
      save  <= COUNT_RESET;
      done  <= 1'b0;
      ovf   <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      save  <= next_save;
      done  <= next_done;
      ovf   <= next_ovf;
    end
  end

  // ==========================================================================
  // dma buffer; a full buffer drops the capture and flags it
  // ==========================================================================
  sample_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_data_i   (push_data),
    .in_ready_o  (fifo_ready),
    .out_valid_o (dma_valid_o),
    .out_data_o  (dma_data_o),
    .out_ready_i (dma_ready_i),
    .level_o     (fifo_level)
  );

  // ==========================================================================
  // wishbone slave
  // ==========================================================================
  // next values: one-cycle ack, byte-lane writes, live readback
  always_comb
  begin
    bus_req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_ack      = bus_req;
    next_ctrl     = ctrl;
    next_arm_req  = 1'b0;
    next_stop_req = 1'b0;
    next_ovf_clr  = 1'b0;
    next_rdata    = 32'h0000_0000;
    if (bus_req && wb_we_i)
    begin
      case (wb_adr_i)
        OFF_CTRL:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel_i[b])
            begin
              next_ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
          end
          next_ctrl.rsvd = '0;
        end
        OFF_CMD:
        begin
          next_arm_req  = wb_sel_i[0] && wb_dat_i[CMD_ARM_BIT];
          next_stop_req = wb_sel_i[0] && wb_dat_i[CMD_DISARM_BIT];
        end
        OFF_STATUS:
        begin
          next_ovf_clr = wb_sel_i[0] && wb_dat_i[STS_OVF_BIT];
        end
        default:
        begin
          next_ctrl = ctrl;  // read-only or unmapped: write ignored
        end
      endcase
    end
    else if (bus_req)
    begin
      case (wb_adr_i)
        OFF_CTRL:   next_rdata = ctrl;
        // reading the count has no side effect
        OFF_COUNT:  next_rdata = count;
        OFF_SAVE:   next_rdata = save;
        OFF_STATUS:
        begin
          next_rdata[STS_ARMED_BIT] = (state != ST_IDLE) && (state != ST_DONE);
          next_rdata[STS_DONE_BIT]  = done;
          next_rdata[STS_OVF_BIT]   = ovf;
          next_rdata[STS_LEVEL_LSB +: $clog2(FIFO_DEPTH+1)] = fifo_level;
        end
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl     <= ctrl_s'(CTRL_RESET);
      arm_req  <= 1'b0;
      stop_req <= 1'b0;
      ovf_clr  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ctrl     <= next_ctrl;
      arm_req  <= next_arm_req;
      stop_req <= next_stop_req;
      ovf_clr  <= next_ovf_clr;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

endmodule : counter_input_measurement

// ==== cim_chk.sv ====
// port assertions for the counter input measurement top
`timescale 1ns/1ps
// ============================================================================
// checker
// ============================================================================
module cim_chk
  import cim_pkg::*;
#(
  parameter int NUM_INPUTS = 7
) (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // wishbone side
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [7:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  // counter lines and dma stream
  input wire logic [NUM_INPUTS-1:0] ctr_in_i,
  input wire logic                  dma_valid_o,
  input wire logic [31:0]           dma_data_o,
  input wire logic                  dma_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_caused: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_write_dat_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero on write");
  a_ctrl_rsvd_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == OFF_CTRL)
    |-> wb_dat_o[31:19] == 13'h0000)
    else $error("reserved control bits not zero");
  a_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > OFF_STATUS)
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_dma_hold_word: assert property (dma_valid_o && !dma_ready_i |=> dma_valid_o && $stable(dma_data_o))
    else $error("dma word changed before taken");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !dma_valid_o)
    else $error("outputs active after reset");
  c_dma_move: cover property (dma_valid_o && dma_ready_i);
  c_save_read: cover property (wb_ack_o && $past(!wb_we_i && wb_adr_i == OFF_SAVE));
  c_arm_write: cover property (wb_ack_o && $past(wb_we_i && wb_adr_i == OFF_CMD));
endmodule : cim_chk

bind counter_input_measurement cim_chk #(.NUM_INPUTS(NUM_INPUTS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ctr_in_i(ctr_in_i), .dma_valid_o(dma_valid_o), .dma_data_o(dma_data_o),
  .dma_ready_i(dma_ready_i));

// ==== cim_far_model.sv ====
// far-side model that drives the routed source, gate and direction lines
`timescale 1ns/1ps
module cim_far_model (
  // clock
  input  wire logic       clk_i,
  // lines: 0 source, 1 gate, 2 direction, rest unselected
  output logic      [6:0] ctr_o
);
  logic       src  = 1'b0; // source level
  logic       gate = 1'b0; // gate level
  logic       dir  = 1'b0; // direction level
  logic [3:0] junk = 4'h0; // unselected lines keep moving so a bad select shows
  always @(posedge clk_i) junk <= junk + 4'h1;
  assign ctr_o = {junk, dir, gate, src};
  // source pulses
  // five clocks per pulse and a settle gap, so the synchronisers see every edge
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_i) src <= 1'b1;
      repeat (2) @(posedge clk_i);
      src <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask : pulse
  // set gate and direction, then let them cross the synchronisers
  task automatic lvl(input logic g, input logic d);
    @(posedge clk_i) gate <= g;
    dir <= d;
    repeat (6) @(posedge clk_i);
  endtask : lvl
endmodule : cim_far_model

// ==== counter_input_measurement_test.sv ====
// self-checking testbench for the counter input measurement block
`timescale 1ns/1ps
module counter_input_measurement_test;
  import cim_pkg::*;
  logic        clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dv, dma_ready = 1'b0, hold = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, ddat, q, tot;
  logic [6:0]  lines;
  logic [31:0] exp_q[$]; // expected dma words in order
  int          mismatches = 0, checks = 0, seed = 32'h07ef242a;
  logic [3:0]  sel = 4'hF; // byte lanes
  localparam int FIFO_WORDS = 9; // memory words plus output stage
  counter_input_measurement u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ctr_in_i(lines), .dma_valid_o(dv), .dma_data_o(ddat), .dma_ready_i(dma_ready));
  cim_far_model u_far (.clk_i(clk_i), .ctr_o(lines));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // drain stalls at random unless held
  always @(posedge clk_i) dma_ready <= !hold && ($random(seed) % 2 != 0);
  always @(posedge clk_i)
    if (dv === 1'b1 && dma_ready === 1'b1)
      chk(ddat, exp_q.size() != 0 ? exp_q.pop_front() : 32'hDEAD_BEEF, "dma word");
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1)
    begin
      mismatches++;
      complete_run();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, e, m);
  endtask : rd
  // program mode, read it back, then arm; flags are pw_high, gate_rise, pause_high, pause_en
  task automatic cfg(input mode_e m, input dir_e d, input logic [3:0] f);
    ctrl_s c;
    c = '0;
    c.mode = m;
    c.dir_mode = d;
    c.src_rise = 1'b1;
    {c.pw_high, c.gate_rise, c.pause_high, c.pause_en} = f;
    c.gate_sel = 3'h1;
    c.dir_sel = 3'h2;
    wb(1'b1, OFF_CTRL, c);
    rd(OFF_CTRL, c, "ctrl readback");
    wb(1'b1, OFF_CMD, 32'h0000_0001);
    repeat (4) @(posedge clk_i);
  endtask : cfg
  task automatic drain();
    int n;
    for (n = 0; exp_q.size() != 0 && n < 800; n++) @(posedge clk_i);
    if (exp_q.size() != 0) chk(exp_q.size(), 0, "dma words left");
  endtask : drain
  initial
  begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_COUNT, COUNT_RESET, "count reset");
    rd(OFF_CTRL, CTRL_RESET, "ctrl reset");
    sel <= 4'h2;
    wb(1'b1, OFF_CTRL, 32'hFFFF_FFFF);
    rd(OFF_CTRL, 32'h0000_FF00, "ctrl lanes");
    sel <= 4'hF;
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000, "unmapped");
    cfg(MODE_COUNT, DIR_UP, 4'h0);
    u_far.pulse(5);
    rd(OFF_COUNT, 5, "count up");
    rd(OFF_COUNT, 5, "count reread");
    cfg(MODE_COUNT, DIR_DOWN, 4'h0);
    u_far.pulse(3);
    rd(OFF_COUNT, 32'hFFFF_FFFD, "count down wrap");
    cfg(MODE_COUNT, DIR_AUX, 4'h0);
    u_far.lvl(1'b0, 1'b1);
    u_far.pulse(3);
    u_far.lvl(1'b0, 1'b0);
    u_far.pulse(1);
    rd(OFF_COUNT, 2, "count aux");
    cfg(MODE_COUNT, DIR_UP, 4'h3);
    u_far.lvl(1'b1, 1'b0);
    u_far.pulse(4);
    u_far.lvl(1'b0, 1'b0);
    u_far.pulse(2);
    rd(OFF_COUNT, 2, "paused count");
    $display("test edge counting done");
    for (int md = 1; md <= 2; md++)
    begin
      cfg(mode_e'(md), DIR_UP, 4'h4);
      tot = 0;
      for (int k = 1; k <= 3; k++)
      begin
        u_far.pulse(k);
        tot += k;
        exp_q.push_back(md == 1 ? tot : k);
        u_far.lvl(1'b1, 1'b0);
        u_far.lvl(1'b0, 1'b0);
      end
      drain();
    end
    wb(1'b1, OFF_CMD, 32'h0000_0002);
    $display("test sampled counting done");
    u_far.lvl(1'b1, 1'b0);
    cfg(MODE_PW_SINGLE, DIR_UP, 4'h8);
    u_far.pulse(2);
    u_far.lvl(1'b0, 1'b0);
    u_far.lvl(1'b1, 1'b0);
    u_far.pulse(4);
    u_far.lvl(1'b0, 1'b0);
    u_far.pulse(3);
    u_far.lvl(1'b1, 1'b0);
    u_far.pulse(2);
    u_far.lvl(1'b0, 1'b0);
    rd(OFF_SAVE, 4, "pulse width");
    wb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, q[STS_DONE_BIT]}, 1, "width done");
    $display("test pulse width done");
    cfg(MODE_PER_SINGLE, DIR_UP, 4'h4);
    u_far.pulse(2);
    u_far.lvl(1'b1, 1'b0);
    u_far.pulse(3);
    u_far.lvl(1'b0, 1'b0);
    u_far.pulse(2);
    u_far.lvl(1'b1, 1'b0);
    rd(OFF_SAVE, 5, "period");
    u_far.lvl(1'b0, 1'b0);
    $display("test period done");
    hold = 1'b1;
    cfg(MODE_BUF_NONCUM, DIR_UP, 4'h4);
    repeat (11)
    begin
      u_far.pulse(1);
      u_far.lvl(1'b1, 1'b0);
      u_far.lvl(1'b0, 1'b0);
    end
    wb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, q[STS_OVF_BIT]}, 1, "fifo overflow");
    repeat (FIFO_WORDS) exp_q.push_back(1);
    hold = 1'b0;
    drain();
    wb(1'b1, OFF_STATUS, 32'h0000_0004);
    wb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({31'h0, q[STS_OVF_BIT]}, 0, "overflow cleared");
    $display("test fifo fill done");
    complete_run();
  end
endmodule : counter_input_measurement_test
